// *** rtl/rbw_params.svh ***
`ifndef RBW_PARAMS_SVH
`define RBW_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define RBW_ADDR_RCB          6'h0B
`define RBW_ADDR_RCB_CMP      6'h1D
`define RBW_ADDR_DEV_CTL      6'h1E
`define RBW_ADDR_CMT_CMP      6'h1F
`define RBW_ADDR_CMT          6'h20

// ----------------------------------------------------------------------------
// Field layouts and reset values
// ----------------------------------------------------------------------------
`define RBW_RCB_MASK          8'hFF
`define RBW_CMT_MASK          8'hC0
`define RBW_CTL_MASK          8'hA3
`define RBW_CTL_SOFT_RST      0
`define RBW_CTL_PAR_EN        1
`define RBW_CTL_CLK_SEL       5
`define RBW_CTL_SCRUB_EN      7
`define RBW_REG_RESET         8'h00
`define RBW_PAR_ODD           1'b1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RBW_CLK_PERIOD_NS     4
`define RBW_BYTE_TIME_NS      80
`define RBW_SOFT_RST_BYTES    32
`define RBW_SOFT_RST_CYC      \
   ((`RBW_SOFT_RST_BYTES * `RBW_BYTE_TIME_NS + `RBW_CLK_PERIOD_NS - 1) / `RBW_CLK_PERIOD_NS)
`define RBW_HALF_FAST         8
`define RBW_HALF_SLOW         10

`endif

// *** rtl/rbw_pkg.sv ***
package rbw_pkg;

   typedef logic [5:0] rbw_addr_t;
   typedef logic [7:0] rbw_byte_t;

   typedef enum logic [0:0] {
      RBW_RST_IDLE = 1'b0,
      RBW_RST_BUSY = 1'b1
   } rbw_rst_e;

endpackage

// *** rtl/rbw_clk_div.sv ***
`timescale 1ns/1ns
`include "rbw_params.svh"

module rbw_clk_div #(
   parameter int HALF_FAST = `RBW_HALF_FAST,
   parameter int HALF_SLOW = `RBW_HALF_SLOW
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   // Control
   input  wire logic i_fast,
   // Divided clock
   output logic      o_clk
);

   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic       clk_q;
   logic       clk_d;
   logic [4:0] half;

   // ---------------------------------------------------------------------------
   // Divider; a change of select mid-period may give one odd pulse
   // ---------------------------------------------------------------------------
   always_comb begin
      half  = i_fast ? 5'(HALF_FAST - 1) : 5'(HALF_SLOW - 1);
      cnt_d = cnt_q + 5'h01;
      clk_d = clk_q;
      if (cnt_q >= half) begin
         cnt_d = 5'h00;
         clk_d = ~clk_q;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_q <= 5'h00;
         clk_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         clk_q <= clk_d;
      end
   end

   assign o_clk = clk_q;

endmodule

// *** rtl/rbw_guard_regs.sv ***
`timescale 1ns/1ns
`include "rbw_params.svh"

// Overview of operation
// - A bus read of receive_cond_b copies its live value into the compare register at 1Dh.
// - A write to receive_cond_b leaves bits that differ from compare and raises the inhibit flag if any differ.
// - The receive_cond_b compare register mirrors receive_cond_b bit for bit, all of D0-D7 used.
// - A bus read of conn_mgmt_cond_reg copies its live value into the compare register at 1Fh.
// - A write to conn_mgmt_cond_reg leaves bits that differ and raises the inhibit flag if any differ.
// - The conn-mgmt compare holds scrub expired in D6 and trigger occurred in D7, D0-D5 zero.
// - The device control register at 1Eh ignores writes while a soft reset is in progress.
// - Writing 1 to soft_reset_bit resets the device; the bit clears itself after 32 byte times.
// - With ctl_bus_parity_enable set, writes with bad parity are discarded; clear means no check.
// - clock_out_select picks the aux clock rate, set giving 15.625 MHz, may glitch on change.
module rbw_guard_regs #(
   parameter int SOFT_RST_CYC = `RBW_SOFT_RST_CYC
) (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   // Control bus
   input  wire logic [5:0] i_cb_addr,
   input  wire logic [7:0] i_cb_wdata,
   input  wire logic       i_cb_wpar,
   input  wire logic       i_cb_rd,
   input  wire logic       i_cb_wr,
   output logic      [7:0] o_cb_rdata,
   output logic            o_cb_rpar,
   // Hardware condition events
   input  wire logic [7:0] i_rcb_set,
   input  wire logic [7:0] i_cmt_set,
   input  wire logic       i_trigger,
   // Device side
   output logic            o_write_inhibit_flag,
   output logic            o_parity_err,
   output logic            o_soft_reset,
   output logic            o_load_trigger_cfg,
   output logic            o_scrub_start,
   output logic            o_aux_clock_out
);

   // ---------------------------------------------------------------------------
   // Parity helper
   // ---------------------------------------------------------------------------
   function automatic logic par_of(input logic [7:0] data);
      par_of = (^data) ^ `RBW_PAR_ODD;
   endfunction

   // ---------------------------------------------------------------------------
   // Strobe aimed at one register address
   // ---------------------------------------------------------------------------
   function automatic logic hit(input logic       strobe,
                                input logic [5:0] addr,
                                input logic [5:0] want);
      hit = strobe && (addr == want);
   endfunction

   rbw_pkg::rbw_byte_t  rcb_q,     rcb_d;
   rbw_pkg::rbw_byte_t  rcb_cmp_q, rcb_cmp_d;
   rbw_pkg::rbw_byte_t  cmt_q,     cmt_d;
   rbw_pkg::rbw_byte_t  cmt_cmp_q, cmt_cmp_d;
   rbw_pkg::rbw_byte_t  ctl_q,     ctl_d;
   rbw_pkg::rbw_byte_t  rdata_q,   rdata_d;
   rbw_pkg::rbw_rst_e   rst_q,     rst_d;
   logic [9:0]          rcnt_q,    rcnt_d;
   logic                rpar_q,    rpar_d;
   logic                inh_q,     inh_d;
   logic                perr_q,    perr_d;
   logic                load_q,    load_d;
   logic                scrub_q,   scrub_d;
   logic                par_bad;
   logic                wr_ok;
   rbw_pkg::rbw_byte_t  rcb_diff;
   rbw_pkg::rbw_byte_t  cmt_diff;

   // ---------------------------------------------------------------------------
   // Write qualification
   // ---------------------------------------------------------------------------
   always_comb begin
      par_bad  = par_of(i_cb_wdata) != i_cb_wpar;
      wr_ok    = i_cb_wr & ~(ctl_q[`RBW_CTL_PAR_EN] & par_bad);
      rcb_diff = rcb_q ^ rcb_cmp_q;
      cmt_diff = (cmt_q ^ cmt_cmp_q) & `RBW_CMT_MASK;
   end

   // ---------------------------------------------------------------------------
   // Guarded condition registers and their compare copies
   // ---------------------------------------------------------------------------
   always_comb begin
      rcb_d     = rcb_q;
      cmt_d     = cmt_q;
      rcb_cmp_d = rcb_cmp_q;
      cmt_cmp_d = cmt_cmp_q;
      inh_d     = 1'b0;
      if (hit(wr_ok, i_cb_addr, `RBW_ADDR_RCB)) begin
         rcb_d = (i_cb_wdata & ~rcb_diff) | (rcb_q & rcb_diff);
         inh_d = |rcb_diff;
      end
      if (hit(wr_ok, i_cb_addr, `RBW_ADDR_CMT)) begin
         cmt_d = ((i_cb_wdata & ~cmt_diff) | (cmt_q & cmt_diff)) & `RBW_CMT_MASK;
         inh_d = |cmt_diff;
      end
      if (hit(wr_ok, i_cb_addr, `RBW_ADDR_RCB_CMP)) begin
         rcb_cmp_d = i_cb_wdata & `RBW_RCB_MASK;
      end
      if (hit(wr_ok, i_cb_addr, `RBW_ADDR_CMT_CMP)) begin
         cmt_cmp_d = i_cb_wdata & `RBW_CMT_MASK;
      end
      // Snapshot is taken last so it wins over a direct compare write
      if (hit(i_cb_rd, i_cb_addr, `RBW_ADDR_RCB)) begin
         rcb_cmp_d = rcb_q;
      end
      if (hit(i_cb_rd, i_cb_addr, `RBW_ADDR_CMT)) begin
         cmt_cmp_d = cmt_q & `RBW_CMT_MASK;
      end
      // Hardware set wins over a same-cycle clear
      rcb_d = rcb_d | i_rcb_set;
      cmt_d = cmt_d | (i_cmt_set & `RBW_CMT_MASK);
   end

   // ---------------------------------------------------------------------------
   // Device control register and soft reset sequencer
   // ---------------------------------------------------------------------------
   always_comb begin
      ctl_d  = ctl_q;
      rst_d  = rst_q;
      rcnt_d = rcnt_q;
      case (rst_q)
         rbw_pkg::RBW_RST_IDLE: begin
            if (hit(wr_ok, i_cb_addr, `RBW_ADDR_DEV_CTL)) begin
               ctl_d = i_cb_wdata & `RBW_CTL_MASK;
               if (i_cb_wdata[`RBW_CTL_SOFT_RST]) begin
                  rst_d  = rbw_pkg::RBW_RST_BUSY;
                  rcnt_d = 10'(SOFT_RST_CYC - 1);
               end
            end
         end
         rbw_pkg::RBW_RST_BUSY: begin
            // Writes to control are dropped here
            if (rcnt_q == 10'h000) begin
               ctl_d[`RBW_CTL_SOFT_RST] = 1'b0;
               rst_d                    = rbw_pkg::RBW_RST_IDLE;
            end else begin
               rcnt_d = rcnt_q - 10'h001;
            end
         end
         default: begin
            rst_d = rbw_pkg::RBW_RST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------------------
   // Read data, parity, event pulses
   // ---------------------------------------------------------------------------
   always_comb begin
      rdata_d = rdata_q;
      if (i_cb_rd) begin
         case (i_cb_addr)
            `RBW_ADDR_RCB:     rdata_d = rcb_q;
            `RBW_ADDR_RCB_CMP: rdata_d = rcb_cmp_q;
            `RBW_ADDR_DEV_CTL: rdata_d = ctl_q;
            `RBW_ADDR_CMT_CMP: rdata_d = cmt_cmp_q;
            `RBW_ADDR_CMT:     rdata_d = cmt_q;
            default:           rdata_d = `RBW_REG_RESET;
         endcase
      end
      rpar_d  = par_of(rdata_d);
      perr_d  = i_cb_wr & ctl_q[`RBW_CTL_PAR_EN] & par_bad;
      load_d  = i_trigger & ctl_q[`RBW_CTL_SCRUB_EN];
      scrub_d = load_q;
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rcb_q     <= `RBW_REG_RESET;
         cmt_q     <= `RBW_REG_RESET;
         rcb_cmp_q <= `RBW_REG_RESET;
         cmt_cmp_q <= `RBW_REG_RESET;
         ctl_q     <= `RBW_REG_RESET;
         rst_q     <= rbw_pkg::RBW_RST_IDLE;
         rcnt_q    <= 10'h000;
         rdata_q   <= `RBW_REG_RESET;
         rpar_q    <= `RBW_PAR_ODD;
         inh_q     <= 1'b0;
         perr_q    <= 1'b0;
         load_q    <= 1'b0;
         scrub_q   <= 1'b0;
      end else begin
         rcb_q     <= rcb_d;
         cmt_q     <= cmt_d;
         rcb_cmp_q <= rcb_cmp_d;
         cmt_cmp_q <= cmt_cmp_d;
         ctl_q     <= ctl_d;
         rst_q     <= rst_d;
         rcnt_q    <= rcnt_d;
         rdata_q   <= rdata_d;
         rpar_q    <= rpar_d;
         inh_q     <= inh_d;
         perr_q    <= perr_d;
         load_q    <= load_d;
         scrub_q   <= scrub_d;
      end
   end

   // ---------------------------------------------------------------------------
   // Aux clock output
   // ---------------------------------------------------------------------------
   rbw_clk_div #(
      .HALF_FAST (`RBW_HALF_FAST),
      .HALF_SLOW (`RBW_HALF_SLOW)
   ) u_clk_div (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_fast    (ctl_q[`RBW_CTL_CLK_SEL]),
      .o_clk     (o_aux_clock_out)
   );

   assign o_cb_rdata           = rdata_q;
   assign o_cb_rpar            = rpar_q;
   assign o_write_inhibit_flag = inh_q;
   assign o_parity_err         = perr_q;
   assign o_soft_reset         = ctl_q[`RBW_CTL_SOFT_RST];
   assign o_load_trigger_cfg   = load_q;
   assign o_scrub_start        = scrub_q;

endmodule

// *** verif/rbw_guard_regs_properties.sv ***
`timescale 1ns/1ns
module rbw_props_chk #(
   parameter int SOFT_RST_CYC = 8
) (
   // Watched ports
   input wire logic       i_clk,
   input wire logic       i_reset_n,
   input wire logic [5:0] i_cb_addr,
   input wire logic [7:0] i_cb_wdata,
   input wire logic       i_cb_wpar,
   input wire logic       i_cb_rd,
   input wire logic       i_cb_wr,
   input wire logic       i_trigger,
   input wire logic [7:0] o_cb_rdata,
   input wire logic       o_cb_rpar,
   input wire logic       o_write_inhibit_flag,
   input wire logic       o_parity_err,
   input wire logic       o_soft_reset,
   input wire logic       o_load_trigger_cfg,
   input wire logic       o_scrub_start
);
   // ----
   // Soft reset length counter
   // ----
   logic [15:0] hi_q;
   logic [15:0] hi_d;
   logic        par_ok;
   assign par_ok = ^{i_cb_wdata, i_cb_wpar};
   always_comb hi_d = o_soft_reset ? hi_q + 16'h0001 : 16'h0000;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         hi_q <= 16'h0000;
      else
         hi_q <= hi_d;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   AST_RPAR: assert property (o_cb_rpar == ~^o_cb_rdata)
      else $error("read parity wrong");
   AST_HOLD: assert property (!i_cb_rd |=> $stable(o_cb_rdata))
      else $error("read data moved without read");
   AST_PERR: assert property (o_parity_err |-> $past(i_cb_wr && !par_ok))
      else $error("parity error without bad write");
   AST_INH: assert property (o_write_inhibit_flag |-> $past(i_cb_wr &&
      (i_cb_addr == 6'h0B || i_cb_addr == 6'h20))) else $error("stray inhibit flag");
   AST_SRST_SET: assert property (i_cb_wr && i_cb_addr == 6'h1E && i_cb_wdata[0]
      && par_ok && !o_soft_reset |=> o_soft_reset) else $error("soft reset not taken");
   AST_SRST_LEN: assert property ($fell(o_soft_reset) |-> hi_q == SOFT_RST_CYC)
      else $error("soft reset length wrong");
   AST_SRST_MAX: assert property (hi_q <= SOFT_RST_CYC)
      else $error("soft reset too long");
   AST_LOAD: assert property (o_load_trigger_cfg |-> $past(i_trigger))
      else $error("load without trigger");
   AST_SCRUB: assert property (o_load_trigger_cfg |=> o_scrub_start)
      else $error("scrub not started");
   AST_COV_INH: cover property (o_write_inhibit_flag);
   AST_COV_SRST: cover property ($fell(o_soft_reset));
   AST_COV_SCRUB: cover property (o_scrub_start);
endmodule
bind rbw_guard_regs rbw_props_chk #(.SOFT_RST_CYC(SOFT_RST_CYC)) u_chk (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cb_addr(i_cb_addr), .i_cb_wdata(i_cb_wdata),
   .i_cb_wpar(i_cb_wpar), .i_cb_rd(i_cb_rd), .i_cb_wr(i_cb_wr), .i_trigger(i_trigger),
   .o_cb_rdata(o_cb_rdata), .o_cb_rpar(o_cb_rpar), .o_parity_err(o_parity_err),
   .o_write_inhibit_flag(o_write_inhibit_flag), .o_soft_reset(o_soft_reset),
   .o_load_trigger_cfg(o_load_trigger_cfg), .o_scrub_start(o_scrub_start));

// *** verif/rbw_host_model.sv ***
`timescale 1ns/1ns
module rbw_host_model (
   // Bus clock and answer
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   // Bus request
   output logic      [5:0] o_addr = 6'h00,
   output logic      [7:0] o_wdata = 8'h00,
   output logic            o_wpar = 1'b1,
   output logic            o_rd = 1'b0,
   output logic            o_wr = 1'b0
);
   // Write with odd parity, spoiled when bad is set
   task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic bad);
      @(posedge i_clk) #1;
      o_addr = a;
      o_wdata = d;
      o_wpar = ~^d ^ bad;
      o_wr = 1'b1;
      @(posedge i_clk) #1;
      o_wr = 1'b0;
      o_wdata = ~d;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge i_clk) #1;
      o_addr = a;
      o_rd = 1'b1;
      @(posedge i_clk) #1;
      o_rd = 1'b0;
      d = i_rdata;
   endtask
endmodule

// *** verif/rbw_guard_regs_tb.sv ***
`timescale 1ns/1ns
module rbw_guard_regs_tb;
   localparam int SRST = 8;
   logic       i_clk = 1'b0;
   logic       i_reset_n = 1'b0;
   logic [5:0] addr;
   logic [7:0] wdata, rdata, d, v, w, df;
   logic       wpar, rd, wr, rpar, inh, perr, srst, ltc, scrub, aux;
   logic [7:0] rcb_set = 8'h00;
   logic [7:0] cmt_set = 8'h00;
   logic       trig = 1'b0;
   logic [7:0] live[2], cmp[2];
   logic [7:0] msk[2] = '{8'hFF, 8'hC0};
   logic [5:0] la[2] = '{6'h0B, 6'h20};
   logic [5:0] ca[2] = '{6'h1D, 6'h1F};
   logic [5:0] ra[4] = '{6'h1D, 6'h1E, 6'h1F, 6'h00};
   int         seed = 32'h16aa;
   int         fail_count = 0;
   int         tests_run = 0;
   int         cyc = 0;
   time        t0;
   always #2 i_clk = ~i_clk;
   rbw_host_model u_host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
      .o_wpar(wpar), .o_rd(rd), .o_wr(wr));
   rbw_guard_regs #(.SOFT_RST_CYC(SRST)) u_dut (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cb_addr(addr), .i_cb_wdata(wdata),
      .i_cb_wpar(wpar), .i_cb_rd(rd), .i_cb_wr(wr), .o_cb_rdata(rdata), .o_cb_rpar(rpar),
      .i_rcb_set(rcb_set), .i_cmt_set(cmt_set), .i_trigger(trig),
      .o_write_inhibit_flag(inh), .o_parity_err(perr), .o_soft_reset(srst),
      .o_load_trigger_cfg(ltc), .o_scrub_start(scrub), .o_aux_clock_out(aux));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic pulse(input int k, input logic [7:0] p);
      @(posedge i_clk) #1;
      if (k == 0) rcb_set = p;
      else if (k == 1) cmt_set = p;
      else trig = p[0];
      @(posedge i_clk) #1;
      rcb_set = 8'h00;
      cmt_set = 8'h00;
      trig = 1'b0;
   endtask
   task automatic do_reset(input int n);
      i_reset_n = 1'b0;
      repeat (n) @(posedge i_clk);
      #1 i_reset_n = 1'b1;
      live = '{8'h00, 8'h00};
      cmp = '{8'h00, 8'h00};
      for (int i = 0; i < 4; i++) begin
         u_host.rd(ra[i], d);
         chk(d, 8'h00);
      end
   endtask
   // Set bits, snapshot, set more, then a guarded write
   task automatic guard(input int k);
      pulse(k, v);
      live[k] = live[k] | (v & msk[k]);
      u_host.rd(la[k], d);
      chk(d, live[k]);
      chk({7'h00, rpar}, {7'h00, ~^d});
      cmp[k] = live[k];
      u_host.rd(ca[k], d);
      chk(d, cmp[k]);
      v = 8'($random(seed));
      pulse(k, v);
      live[k] = live[k] | (v & msk[k]);
      w = 8'($random(seed));
      u_host.wr(la[k], w, 1'b0);
      chk({7'h00, inh}, {7'h00, live[k] != cmp[k]});
      df = live[k] ^ cmp[k];
      live[k] = ((w & ~df) | (live[k] & df)) & msk[k];
      u_host.rd(la[k], d);
      chk(d, live[k]);
      cmp[k] = live[k];
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   initial begin
      v = 8'h00;
      do_reset(20);
      for (int i = 0; i < 8; i++) begin
         v = 8'($random(seed));
         guard(i % 2);
      end
      for (int p = 0; p < 2; p++) begin
         u_host.wr(6'h1E, {6'h00, p[0], 1'b0}, 1'b0);
         v = 8'($random(seed));
         u_host.wr(6'h1D, v, 1'b1);
         chk({7'h00, perr}, {7'h00, p[0]});
         if (p == 0) cmp[0] = v;
         u_host.rd(6'h1D, d);
         chk(d, cmp[0]);
      end
      v = 8'($random(seed));
      u_host.wr(6'h1F, v, 1'b0);
      u_host.rd(6'h1F, d);
      chk(d, v & 8'hC0);
      chk({7'h00, rpar}, {7'h00, ~^d});
      for (int c = 0; c < 4; c++) begin
         u_host.wr(6'h1E, {c[1], 1'b0, c[0], 5'h02}, 1'b0);
         repeat (2) @(posedge aux);
         t0 = $time;
         @(posedge aux);
         chk(8'(($time - t0) / 4), c[0] ? 8'h10 : 8'h14);
         pulse(2, 8'h01);
         chk({7'h00, ltc}, {7'h00, c[1]});
         @(posedge i_clk) #1;
         chk({7'h00, scrub}, {7'h00, c[1]});
      end
      u_host.wr(6'h1E, 8'h03, 1'b0);
      chk({7'h00, srst}, 8'h01);
      u_host.wr(6'h1E, 8'h22, 1'b0);
      u_host.rd(6'h1E, d);
      chk(d, 8'h03);
      repeat (SRST) @(posedge i_clk);
      u_host.rd(6'h1E, d);
      chk(d, 8'h02);
      chk({7'h00, srst}, 8'h00);
      do_reset(2);
      stop_test();
   end
endmodule
